/* File: logic/sci_pkg.sv */
// Constants shared by the serial data path and its rate generator
`default_nettype none
package sci_pkg;
   localparam int unsigned ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_STATUS   = 8'h50;
   localparam logic [7:0] IDX_DATA     = 8'h51;
   localparam logic [7:0] IDX_BAUD     = 8'h52;
   localparam logic [7:0] IDX_FRAME    = 8'h53;
   localparam logic [7:0] IDX_CTRL     = 8'h54;
   localparam logic [7:0] IDX_RX_FINE  = 8'h55;
   localparam logic [7:0] IDX_GAP      = 8'h56;
   localparam logic [7:0] IDX_TX_FINE  = 8'h57;
   localparam logic [7:0] IDX_EVT_STS  = 8'h58;
   localparam logic [7:0] IDX_EVT_CLR  = 8'h59;
   localparam logic [7:0] IDX_EVT_EN   = 8'h5A;
   // Reset values and frame write mask
   localparam logic [7:0] STATUS_RST   = 8'hC0;
   localparam logic [7:0] BAUD_RST     = 8'h00;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] FINE_RST     = 8'h00;
   localparam logic [7:0] FRAME_MASK   = 8'h58;
   // Field positions
   localparam int unsigned PS_LSB  = 6;
   localparam int unsigned TXP_LSB = 3;
   localparam int unsigned RXP_LSB = 0;
   localparam int unsigned CTRL_TE = 3;
   localparam int unsigned CTRL_RX_ON = 2;
   // Event bits
   localparam int unsigned EV_TX_EMPTY = 0;
   localparam int unsigned EV_TX_DONE  = 1;
   localparam int unsigned EV_RX_READY = 2;
   localparam int unsigned EV_OVERRUN  = 3;
   localparam int unsigned EV_N        = 4;
   // Coarse prescale factors by code
   localparam logic [3:0] PF_CODE0 = 4'h1;
   localparam logic [3:0] PF_CODE1 = 4'h3;
   localparam logic [3:0] PF_CODE2 = 4'h4;
   localparam logic [3:0] PF_CODE3 = 4'hD;
   // Rate clock is sixteen times the bit rate
   localparam logic [3:0] SUB_LAST = 4'hF;
   localparam logic [3:0] SUB_MID  = 4'h7;
   localparam logic [3:0] BIT_STOP = 4'h9;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: logic/rate_if.sv */
// Divider settings down to the rate generator, rate ticks back
`timescale 1ns/1ns
`default_nettype none
interface rate_if;
   logic [1:0] coarse_prescale_sel;
   logic [2:0] tx_pow2_divisor_sel;
   logic [2:0] rx_pow2_divisor_sel;
   logic [7:0] tx_fine_factor;
   logic [7:0] rx_fine_factor;
   logic       tx_tick;
   logic       rx_tick;
   modport gen (input coarse_prescale_sel, tx_pow2_divisor_sel, rx_pow2_divisor_sel,
                input tx_fine_factor, rx_fine_factor, output tx_tick, rx_tick);
   modport core (output coarse_prescale_sel, tx_pow2_divisor_sel, rx_pow2_divisor_sel,
                 output tx_fine_factor, rx_fine_factor, input tx_tick, rx_tick);
endinterface
`default_nettype wire

/* File: logic/baud_tick_gen.sv */
// Transmit and receive rate tick generator
`timescale 1ns/1ns
`default_nettype none
module baud_tick_gen
   import sci_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   rate_if.gen      rt
);
   typedef struct packed {
      logic [11:0] tx_cnt;
      logic [11:0] rx_cnt;
      logic        tx_tick;
      logic        rx_tick;
   } gen_st_t;

   gen_st_t st_r;
   gen_st_t st_nxt;
   logic [11:0] tx_div;
   logic [11:0] rx_div;

   function automatic logic [11:0] divisor(input logic [1:0] ps, input logic [2:0] p2,
                                           input logic [7:0] fine);
      logic [3:0] pf;
      logic [7:0] f;
      begin
         case (ps)
            2'h0:    pf = PF_CODE0;
            2'h1:    pf = PF_CODE1;
            2'h2:    pf = PF_CODE2;
            default: pf = PF_CODE3;
         endcase
         // Non-zero fine factor replaces the power-of-two divisor
         f = (fine != 8'h00) ? fine : (8'h01 << p2);
         divisor = 12'(pf) * 12'(f);
      end
   endfunction

   assign tx_div = divisor(rt.coarse_prescale_sel, rt.tx_pow2_divisor_sel, rt.tx_fine_factor);
   assign rx_div = divisor(rt.coarse_prescale_sel, rt.rx_pow2_divisor_sel, rt.rx_fine_factor);
   assign rt.tx_tick = st_r.tx_tick;
   assign rt.rx_tick = st_r.rx_tick;

   always_comb begin
      st_nxt = st_r;
      // >= so a smaller divisor written mid-count takes effect at once
      if (st_r.tx_cnt >= 12'(tx_div - 12'h001)) begin
         st_nxt.tx_cnt  = 12'h000;
         st_nxt.tx_tick = 1'b1;
      end else begin
         st_nxt.tx_cnt  = 12'(st_r.tx_cnt + 12'h001);
         st_nxt.tx_tick = 1'b0;
      end
      if (st_r.rx_cnt >= 12'(rx_div - 12'h001)) begin
         st_nxt.rx_cnt  = 12'h000;
         st_nxt.rx_tick = 1'b1;
      end else begin
         st_nxt.rx_cnt  = 12'(st_r.rx_cnt + 12'h001);
         st_nxt.rx_tick = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: logic/sci_data_baud.sv */
// Serial data holding registers, flags, shifters and AXI4-Lite register file
// Summary of operation
// - Data write loads transmit holder, read returns receive
// - Prescale code selects factor 1, 3, 4, 13
// - Transmit rate uses prescale times power-of-two divisor
// - Receive rate uses prescale times power-of-two divisor
// - Non-zero transmit fine factor replaces power-of-two divisor
// - Non-zero receive fine factor replaces power-of-two divisor
// - Receive fine factor divides the sixteen-times rate
// - Transmit fine factor divides the sixteen-times rate
// - Both fine dividers reset to zero
// - Transmit empty sets on transfer, clears status-then-write
// - Receive ready clears on receiver off or status-then-read
`timescale 1ns/1ns
`default_nettype none
module sci_data_baud
   import sci_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              rxd,
   output logic                   txd,
   output logic                   irq
);
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              arready;
      logic              aw_hold;
      logic [ADDR_W-3:0] aw_word;
      logic              w_hold;
      logic [7:0]        w_byte;
      logic              w_lane;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [7:0]        rbyte;
      logic [7:0]        tx_holding_reg;
      logic [7:0]        rx_holding_reg;
      logic [7:0]        baud;
      logic [7:0]        frame;
      logic [7:0]        ctrl;
      logic [7:0]        rx_fine;
      logic [7:0]        tx_fine;
      logic              tx_empty_flag;
      logic              tx_done;
      logic              rx_ready_flag;
      logic              overrun;
      logic              frame_err;
      logic              status_seen;
      logic [EV_N-1:0]   evt_sts;
      logic [EV_N-1:0]   evt_en;
      logic              irq;
      logic              txd;
      logic              tx_busy;
      logic [9:0]        tx_shift;
      logic [3:0]        tx_bit;
      logic [3:0]        tx_sub;
      logic              rxd_meta;
      logic              rxd_sync;
      logic              rx_busy;
      logic [3:0]        rx_bit;
      logic [3:0]        rx_sub;
      logic [7:0]        rx_shift;
   } core_st_t;

   core_st_t st_r;
   core_st_t st_nxt;
   core_st_t st_rst;
   rate_if   rt ();

   function automatic logic mapped(input logic [ADDR_W-3:0] w);
      begin
         mapped = (w >= (ADDR_W-2)'(IDX_STATUS)) && (w <= (ADDR_W-2)'(IDX_EVT_EN));
      end
   endfunction

   function automatic logic at(input logic [ADDR_W-3:0] w, input logic [7:0] idx);
      begin
         at = (w == (ADDR_W-2)'(idx));
      end
   endfunction

   always_comb begin
      st_rst               = '0;
      st_rst.baud          = BAUD_RST;
      st_rst.ctrl          = CTRL_RST;
      st_rst.rx_fine       = FINE_RST;
      st_rst.tx_fine       = FINE_RST;
      st_rst.tx_empty_flag = STATUS_RST[7];
      st_rst.tx_done       = STATUS_RST[6];
      st_rst.txd           = 1'b1;
      st_rst.rxd_meta      = 1'b1;
      st_rst.rxd_sync      = 1'b1;
   end

   baud_tick_gen u_gen (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rt      (rt.gen)
   );

   assign rt.coarse_prescale_sel = st_r.baud[PS_LSB +: 2];
   assign rt.tx_pow2_divisor_sel = st_r.baud[TXP_LSB +: 3];
   assign rt.rx_pow2_divisor_sel = st_r.baud[RXP_LSB +: 3];
   assign rt.tx_fine_factor      = st_r.tx_fine;
   assign rt.rx_fine_factor      = st_r.rx_fine;

   always_comb begin
      logic [EV_N-1:0] ev;
      logic [7:0]      status_val;
      logic            data_wr;
      logic            data_rd;
      ev         = '0;
      status_val = '0;
      data_wr    = 1'b0;
      data_rd    = 1'b0;
      st_nxt     = st_r;
      status_val = {st_r.tx_empty_flag, st_r.tx_done, st_r.rx_ready_flag, 1'b0,
                    st_r.overrun, 1'b0, st_r.frame_err, 1'b0};

      // Write channel: address and data taken in either order
      if (awvalid && st_r.awready) begin
         st_nxt.aw_hold = 1'b1;
         st_nxt.aw_word = awaddr[ADDR_W-1:2];
      end
      if (wvalid && st_r.wready) begin
         st_nxt.w_hold = 1'b1;
         st_nxt.w_byte = wdata[7:0];
         st_nxt.w_lane = wstrb[0];
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_hold && st_r.w_hold && !st_r.bvalid) begin
         st_nxt.aw_hold = 1'b0;
         st_nxt.w_hold  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = mapped(st_r.aw_word) ? RESP_OKAY : RESP_SLVERR;
         if (mapped(st_r.aw_word) && st_r.w_lane) begin
            if (at(st_r.aw_word, IDX_DATA)) begin
               st_nxt.tx_holding_reg = st_r.w_byte;
               data_wr = 1'b1;
            end
            if (at(st_r.aw_word, IDX_BAUD)) begin
               st_nxt.baud = st_r.w_byte;
            end
            if (at(st_r.aw_word, IDX_FRAME)) begin
               st_nxt.frame = st_r.w_byte & FRAME_MASK;
            end
            if (at(st_r.aw_word, IDX_CTRL)) begin
               st_nxt.ctrl = st_r.w_byte;
            end
            if (at(st_r.aw_word, IDX_RX_FINE)) begin
               st_nxt.rx_fine = st_r.w_byte;
            end
            if (at(st_r.aw_word, IDX_TX_FINE)) begin
               st_nxt.tx_fine = st_r.w_byte;
            end
            if (at(st_r.aw_word, IDX_EVT_CLR)) begin
               st_nxt.evt_sts = st_r.evt_sts & ~st_r.w_byte[EV_N-1:0];
            end
            if (at(st_r.aw_word, IDX_EVT_EN)) begin
               st_nxt.evt_en = st_r.w_byte[EV_N-1:0];
            end
         end
      end

      // Read channel: answer one cycle after the address is taken
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
         st_nxt.rbyte  = 8'h00;
         if (at(araddr[ADDR_W-1:2], IDX_STATUS)) begin
            st_nxt.rbyte       = status_val;
            st_nxt.status_seen = 1'b1;
         end
         if (at(araddr[ADDR_W-1:2], IDX_DATA)) begin
            st_nxt.rbyte = st_r.rx_holding_reg;
            data_rd = 1'b1;
         end
         if (at(araddr[ADDR_W-1:2], IDX_BAUD)) begin
            st_nxt.rbyte = st_r.baud;
         end
         if (at(araddr[ADDR_W-1:2], IDX_FRAME)) begin
            st_nxt.rbyte = st_r.frame;
         end
         if (at(araddr[ADDR_W-1:2], IDX_CTRL)) begin
            st_nxt.rbyte = st_r.ctrl;
         end
         if (at(araddr[ADDR_W-1:2], IDX_RX_FINE)) begin
            st_nxt.rbyte = st_r.rx_fine;
         end
         if (at(araddr[ADDR_W-1:2], IDX_TX_FINE)) begin
            st_nxt.rbyte = st_r.tx_fine;
         end
         if (at(araddr[ADDR_W-1:2], IDX_EVT_STS)) begin
            st_nxt.rbyte = 8'(st_r.evt_sts);
         end
         if (at(araddr[ADDR_W-1:2], IDX_EVT_EN)) begin
            st_nxt.rbyte = 8'(st_r.evt_en);
         end
      end

      // Clearing sequences come first so a same-cycle hardware set wins
      if (st_r.status_seen && data_wr) begin
         st_nxt.tx_empty_flag = 1'b0;
         st_nxt.tx_done       = 1'b0;
         st_nxt.status_seen   = 1'b0;
      end
      if (st_r.status_seen && data_rd) begin
         st_nxt.rx_ready_flag = 1'b0;
         st_nxt.overrun       = 1'b0;
         st_nxt.frame_err     = 1'b0;
         st_nxt.status_seen   = 1'b0;
      end

      // Transmitter; no transfer in a cycle that rewrites the holder
      if (!st_r.tx_busy && !st_r.tx_empty_flag && st_r.ctrl[CTRL_TE] && !data_wr) begin
         st_nxt.tx_busy       = 1'b1;
         st_nxt.tx_shift      = {1'b1, st_r.tx_holding_reg, 1'b0};
         st_nxt.tx_bit        = 4'h0;
         st_nxt.tx_sub        = 4'h0;
         st_nxt.tx_empty_flag = 1'b1;
         ev[EV_TX_EMPTY]      = 1'b1;
      end
      if (st_r.tx_busy && rt.tx_tick) begin
         st_nxt.tx_sub = 4'(st_r.tx_sub + 4'h1);
         if (st_r.tx_sub == SUB_LAST) begin
            st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
            st_nxt.tx_bit   = 4'(st_r.tx_bit + 4'h1);
            if (st_r.tx_bit == BIT_STOP) begin
               st_nxt.tx_busy = 1'b0;
               if (st_r.tx_empty_flag) begin
                  st_nxt.tx_done = 1'b1;
                  ev[EV_TX_DONE] = 1'b1;
               end
            end
         end
      end
      st_nxt.txd = st_nxt.tx_busy ? st_nxt.tx_shift[0] : 1'b1;

      // Receiver, sampling each bit at its middle rate tick
      st_nxt.rxd_meta = rxd;
      st_nxt.rxd_sync = st_r.rxd_meta;
      if (!st_r.ctrl[CTRL_RX_ON]) begin
         st_nxt.rx_busy       = 1'b0;
         st_nxt.rx_ready_flag = 1'b0;
         st_nxt.overrun       = 1'b0;
         st_nxt.frame_err     = 1'b0;
      end else if (!st_r.rx_busy) begin
         if (!st_r.rxd_sync) begin
            st_nxt.rx_busy = 1'b1;
            st_nxt.rx_bit  = 4'h0;
            st_nxt.rx_sub  = 4'h0;
         end
      end else if (rt.rx_tick) begin
         st_nxt.rx_sub = 4'(st_r.rx_sub + 4'h1);
         if (st_r.rx_sub == SUB_MID) begin
            st_nxt.rx_bit = 4'(st_r.rx_bit + 4'h1);
            if (st_r.rx_bit == 4'h0) begin
               // A start bit gone high by mid-bit was a glitch
               st_nxt.rx_busy = ~st_r.rxd_sync;
            end else if (st_r.rx_bit != BIT_STOP) begin
               st_nxt.rx_shift = {st_r.rxd_sync, st_r.rx_shift[7:1]};
            end else begin
               st_nxt.rx_busy = 1'b0;
               if (st_r.rx_ready_flag) begin
                  // Holder keeps the unread byte; this frame is dropped
                  st_nxt.overrun  = 1'b1;
                  ev[EV_OVERRUN]  = 1'b1;
               end else begin
                  st_nxt.rx_holding_reg = st_r.rx_shift;
                  st_nxt.rx_ready_flag  = 1'b1;
                  st_nxt.frame_err      = ~st_r.rxd_sync;
                  ev[EV_RX_READY]       = 1'b1;
               end
            end
         end
      end

      st_nxt.evt_sts = st_nxt.evt_sts | ev;
      st_nxt.irq     = |(st_nxt.evt_sts & st_nxt.evt_en);
      st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_hold && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= st_rst;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign awready = st_r.awready;
   assign wready  = st_r.wready;
   assign bvalid  = st_r.bvalid;
   assign bresp   = st_r.bresp;
   assign arready = st_r.arready;
   assign rvalid  = st_r.rvalid;
   assign rresp   = st_r.rresp;
   assign rdata   = {24'h000000, st_r.rbyte};
   assign txd     = st_r.txd;
   assign irq     = st_r.irq;
endmodule
`default_nettype wire

/* File: tb/sci_data_baud_properties.sv */
// Port-level properties of the serial data path and rate block
`timescale 1ns/1ns
`default_nettype none
module sci_data_baud_properties
   import sci_pkg::*;
(
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic              bvalid,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic              txd
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [9:0] ar_idx;
   assign ar_idx = araddr[ADDR_W-1:2];

   property p_read_answer;
      arvalid && arready |=> rvalid && rdata[31:8] == 24'h0;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late or too wide");
   property p_read_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read data dropped before taken");
   property p_write_answer;
      awvalid && awready && wvalid && wready |-> ##2 bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write answer late");
   property p_gap_read;
      arvalid && arready && ar_idx == {2'h0, IDX_GAP} |=> rdata == 32'h0 && rresp == RESP_OKAY;
   endproperty
   a_gap_read: assert property (p_gap_read)
      else $error("gap address not zero");
   property p_unmapped_read;
      arvalid && arready && (ar_idx < {2'h0, IDX_STATUS} || ar_idx > {2'h0, IDX_EVT_EN})
         |=> rresp == RESP_SLVERR && rdata == 32'h0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not refused");
   property p_idle_after_reset;
      $rose(aresetn) |-> txd [*8];
   endproperty
   a_idle_after_reset: assert property (p_idle_after_reset)
      else $error("line left idle after reset");
   // Shortest legal bit is sixteen clocks, fine factor 1 and prescale 1
   property p_bit_low;
      $fell(txd) |-> !txd [*8] ##1 !txd [*8];
   endproperty
   a_bit_low: assert property (p_bit_low)
      else $error("low bit shorter than sixteen clocks");
   property p_bit_high;
      $rose(txd) |-> txd [*8] ##1 txd [*8];
   endproperty
   a_bit_high: assert property (p_bit_high)
      else $error("high bit shorter than sixteen clocks");

   c_tx_frame: cover property ($fell(txd));
   c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
   c_gap: cover property (arvalid && arready && ar_idx == {2'h0, IDX_GAP});
endmodule

bind sci_data_baud sci_data_baud_properties u_props (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .txd(txd)
);
`default_nettype wire

/* File: tb/serial_peer.sv */
// Remote serial peer: frame receiver with bit timing, and frame sender
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   input  wire logic aclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0]  got;
   int unsigned bit_cyc;
   int unsigned frames;
   time         t0;
   initial begin
      rxd = 1'b1;
      frames = 0;
      bit_cyc = 0;
   end
   // Start bit may be short by part of a tick, so bit 0 is timed instead
   // Sent bytes therefore need bit 0 set and bit 1 clear
   always begin
      @(negedge txd);
      @(posedge txd);
      t0 = $time;
      @(negedge txd);
      bit_cyc = int'(($time - t0) / 8);
      got[0] = 1'b1;
      #(bit_cyc * 4);
      for (int i = 1; i < 8; i++) begin
         got[i] = txd;
         #(bit_cyc * 8);
      end
      frames++;
   end
   // Line rests high between frames, as the stop bit leaves it
   task automatic send(input logic [7:0] v, input int unsigned cyc);
      logic [9:0] fr;
      fr = {1'b1, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge aclk);
         rxd <= fr[i];
         repeat (cyc - 1) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the serial data path and rate generator
`timescale 1ns/1ns
`default_nettype none
module tb
   import sci_pkg::*;
;
   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic              rxd;
   logic              txd;
   logic              irq;
   int                mismatches;
   int                samples_checked;
   logic [31:0]       d;
   logic [1:0]        r;
   logic [7:0]        b;
   int unsigned       n;
   int unsigned       e;
   logic [7:0]        rst_idx [6] = '{IDX_STATUS, IDX_BAUD, IDX_CTRL, IDX_RX_FINE,
                                      IDX_TX_FINE, IDX_EVT_EN};
   logic [7:0]        rst_val [6] = '{STATUS_RST, BAUD_RST, CTRL_RST, FINE_RST, FINE_RST, 8'h00};
   logic [7:0]        tx_baud [7] = '{8'h00, 8'h08, 8'h50, 8'h98, 8'hC0, 8'h7F, 8'h00};
   logic [7:0]        tx_fine [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01};
   logic [7:0]        rx_baud [3] = '{8'h00, 8'h42, 8'h47};
   logic [7:0]        rx_fine [3] = '{8'h01, 8'h00, 8'h07};
   logic [3:0]        pf_tab  [4] = '{PF_CODE0, PF_CODE1, PF_CODE2, PF_CODE3};

   sci_data_baud u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rxd(rxd), .txd(txd), .irq(irq)
   );
   serial_peer u_peer (.aclk(aclk), .txd(txd), .rxd(rxd));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   function automatic int unsigned bit_cycles(input logic [7:0] bd, input logic [7:0] fine,
                                              input logic [2:0] sel);
      return 16 * int'(pf_tab[bd[7:6]]) * ((fine != 8'h00) ? int'(fine) : (1 << sel));
   endfunction

   task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_flag(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic aw_done;
      logic w_done;
      @(posedge aclk);
      awaddr  <= {2'h0, idx, 2'h0};
      awvalid <= 1'b1;
      wdata   <= {24'h0, v};
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_done = 1'b0;
      w_done  = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx);
      @(posedge aclk);
      araddr  <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Status read arms the clear, data write releases the byte
   task automatic tx_byte(input logic [7:0] v);
      n = u_peer.frames + 1;
      rd(IDX_STATUS);
      wr(IDX_DATA, v);
      for (int i = 0; i < 45000 && u_peer.frames != n; i++) @(posedge aclk);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (95000) @(posedge aclk);
      mismatches++;
      print_verdict();
   end

   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, aresetn} = '0;
      mismatches = 0;
      samples_checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_idx[k]) begin
         rd(rst_idx[k]);
         chk_data("reset value", {24'h0, rst_val[k]}, d);
      end
      wr(IDX_GAP, 8'hFF);
      chk_data("gap write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd(IDX_GAP);
      chk_data("gap read", 32'h0, d);
      rd(8'hC0);
      chk_data("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(IDX_RX_FINE, 8'hFF);
      rd(IDX_RX_FINE);
      chk_data("rx fine", 32'hFF, d);
      $display("register test done");
      wr(IDX_CTRL, 8'h0C);
      for (int k = 0; k < 7; k++) begin
         wr(IDX_BAUD, tx_baud[k]);
         wr(IDX_TX_FINE, tx_fine[k]);
         b = 8'hA5 ^ {k[2:0], 5'h0};
         tx_byte(b);
         e = bit_cycles(tx_baud[k], tx_fine[k], tx_baud[k][5:3]);
         chk_data("tx byte", {24'h0, b}, {24'h0, u_peer.got});
         chk_data("tx bit cycles", e, u_peer.bit_cyc);
         rd(IDX_STATUS);
         chk_flag("tx empty", 1'b1, d[7]);
      end
      // Data read spends the armed clear, so the write below must not send
      rd(IDX_DATA);
      n = u_peer.frames;
      wr(IDX_DATA, 8'h59);
      repeat (200) @(posedge aclk);
      chk_data("frames held", n, u_peer.frames);
      tx_byte(8'h59);
      chk_data("tx byte", 32'h59, {24'h0, u_peer.got});
      $display("transmit test done");
      for (int k = 0; k < 3; k++) begin
         wr(IDX_BAUD, rx_baud[k]);
         wr(IDX_RX_FINE, rx_fine[k]);
         wr(IDX_EVT_EN, (k == 2) ? 8'h00 : 8'h04);
         b = 8'h3D + 8'(k);
         e = bit_cycles(rx_baud[k], rx_fine[k], rx_baud[k][2:0]);
         u_peer.send(b, e);
         repeat (4) @(posedge aclk);
         chk_flag("irq", k != 2, irq);
         rd(IDX_STATUS);
         chk_flag("rx ready", 1'b1, d[5]);
         rd(IDX_DATA);
         chk_data("rx byte", {24'h0, b}, d);
         rd(IDX_STATUS);
         chk_flag("rx ready clear", 1'b0, d[5]);
         wr(IDX_EVT_CLR, 8'h04);
         repeat (2) @(posedge aclk);
         chk_flag("irq clear", 1'b0, irq);
      end
      u_peer.send(8'h77, e);
      repeat (4) @(posedge aclk);
      rd(IDX_STATUS);
      chk_flag("rx ready", 1'b1, d[5]);
      wr(IDX_CTRL, 8'h08);
      rd(IDX_STATUS);
      chk_flag("rx ready off", 1'b0, d[5]);
      $display("receive test done");
      print_verdict();
   end
endmodule
`default_nettype wire
